// *** coil_link_pkg.sv ***
package coil_link_pkg;

  localparam logic [7:0]  FUNC_WRITE_COIL = 8'h05;
  localparam logic [7:0]  ADDR_BROADCAST  = 8'h00;
  localparam logic [7:0]  ADDR_OFFSET     = 8'h01;
  localparam logic [15:0] COIL_HOME       = 16'h049C;
  localparam logic [15:0] COIL_SEARCH     = 16'h049D;
  localparam logic [15:0] DATA_ON         = 16'hFF00;
  localparam logic [15:0] DATA_OFF        = 16'h0000;
  localparam logic [3:0]  FRAME_BYTES     = 4'h8;
  localparam logic [3:0]  EXC_BYTES       = 4'h5;
  localparam logic [3:0]  QUERY_BODY      = 4'h6;
  localparam logic [3:0]  EXC_BODY        = 4'h3;
  localparam logic [7:0]  EXC_FLAG        = 8'h80;
  localparam logic [7:0]  EXC_BAD_FUNC    = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDR    = 8'h02;
  localparam logic [7:0]  EXC_BAD_DATA    = 8'h03;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE     = 16'h0000;
  localparam int          SILENT_CYC      = 16;
  localparam int          BYTE_CYC        = 4;
  localparam int          RESP_CYC        = 200;
  localparam int          CNT_W           = 8;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

endpackage : coil_link_pkg

// *** coil_link_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface coil_link_if (input wire logic clk);
  logic [7:0] q_data;
  logic       q_valid;
  logic [7:0] r_data;
  logic       r_valid;
  modport master (output q_data, output q_valid, input r_data, input r_valid);
  modport slave  (input q_data, input q_valid, output r_data, output r_valid);
endinterface : coil_link_if
`default_nettype wire

// *** coil_slave.sv ***
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Own address is axis plus one; 00 broadcasts
// - Only function 05 writes a coil
// - Coil 049C holds home request, FF00/0000
// - Home move starts only on 0000 to FF00
// - Master writes 0000 then FF00 for edge
// - Coil 049D selects stop after search
// - Query frame is exactly eight bytes
// - Trailing CRC checked before acting
// - Silent gaps mark frame start and end
// - Successful write echoed byte for byte, except broadcast
// - Invalid data gets exception or silence
module coil_slave #(
  parameter int SILENT_CYC = coil_link_pkg::SILENT_CYC,
  parameter int BYTE_CYC   = coil_link_pkg::BYTE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  coil_link_if.slave      link,
  input  wire logic [3:0] axis_no,
  output logic            home_move_start,
  output logic            home_coil,
  output logic            search_end_stop,
  output logic            frame_drop
);

  typedef enum logic [1:0] {
    ST_RX  = 2'b00,
    ST_TX  = 2'b01,
    ST_GAP = 2'b10
  } slave_state_t;

  localparam logic [7:0] SILENT_N = 8'(SILENT_CYC);
  localparam logic [7:0] BYTE_N   = 8'(BYTE_CYC - 1);

  slave_state_t state_r;
  slave_state_t state_nxt;
  logic [7:0]   buf_r [0:7];
  logic [3:0]   cnt_r;
  logic         ovf_r;
  logic [15:0]  crc_r;
  logic [7:0]   idle_r;
  logic [7:0]   pace_r;
  logic [3:0]   tx_idx_r;
  logic [3:0]   tx_len_r;
  logic         tx_exc_r;
  logic [7:0]   r_data_r;
  logic         r_valid_r;
  logic         home_r;
  logic         search_r;
  logic         start_r;
  logic         drop_r;

  wire  [7:0]  own_addr   = 8'({4'h0, axis_no}) + coil_link_pkg::ADDR_OFFSET;
  wire         addr_own   = buf_r[0] == own_addr;
  wire         addr_bcast = buf_r[0] == coil_link_pkg::ADDR_BROADCAST;
  wire         len_ok     = (cnt_r == coil_link_pkg::FRAME_BYTES) && !ovf_r;
  wire         crc_ok     = crc_r == coil_link_pkg::CRC_RESIDUE;
  wire         func_ok    = buf_r[1] == coil_link_pkg::FUNC_WRITE_COIL;
  wire  [15:0] coil_addr  = {buf_r[2], buf_r[3]};
  wire  [15:0] coil_data  = {buf_r[4], buf_r[5]};
  wire         is_home    = coil_addr == coil_link_pkg::COIL_HOME;
  wire         is_search  = coil_addr == coil_link_pkg::COIL_SEARCH;
  wire         data_on    = coil_data == coil_link_pkg::DATA_ON;
  wire         data_ok    = data_on || (coil_data == coil_link_pkg::DATA_OFF);
  wire         frame_end  = (state_r == ST_RX) && (cnt_r != 4'h0) && (idle_r >= SILENT_N);
  wire         accept     = frame_end && len_ok && crc_ok && (addr_own || addr_bcast);
  wire         write_ok   = accept && func_ok && (is_home || is_search) && data_ok;
  wire         reply      = accept && !addr_bcast;
  wire  [7:0]  exc_code   = !func_ok ? coil_link_pkg::EXC_BAD_FUNC :
                            !(is_home || is_search) ? coil_link_pkg::EXC_BAD_ADDR :
                            coil_link_pkg::EXC_BAD_DATA;
  wire         rx_byte    = (state_r == ST_RX) && link.q_valid;
  wire         tx_fire    = (state_r == ST_TX) && (pace_r == 8'h00);
  wire         tx_last    = tx_fire && (tx_idx_r == tx_len_r - 4'h1);
  wire         gap_done   = (state_r == ST_GAP) && (idle_r >= SILENT_N);
  wire  [7:0]  tx_byte    = !tx_exc_r ? buf_r[tx_idx_r[2:0]] :
                            (tx_idx_r < coil_link_pkg::EXC_BODY) ? buf_r[tx_idx_r[2:0]] :
                            (tx_idx_r == coil_link_pkg::EXC_BODY) ? crc_r[7:0] :
                            crc_r[15:8];

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RX:
      begin
        if (reply)
        begin
          state_nxt = ST_TX;
        end
      end
      ST_TX:
      begin
        if (tx_last)
        begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (gap_done)
        begin
          state_nxt = ST_RX;
        end
      end
      default:
      begin
        state_nxt = ST_RX;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_RX;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Silence counter, restarted by every query byte, by a frame end and by the last reply byte
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_r <= 8'h00;
    end
    else if (link.q_valid || tx_last || frame_end)
    begin
      idle_r <= 8'h00;
    end
    else if (idle_r != 8'hFF)
    begin
      idle_r <= idle_r + 8'h01;
    end
  end

  // Frame capture, CRC and exception rewrite share one byte store
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= 4'h0;
      ovf_r <= 1'b0;
      crc_r <= coil_link_pkg::CRC_INIT;
      for (int i = 0; i < 8; i++)
      begin
        buf_r[i] <= 8'h00;
      end
    end
    else if (frame_end)
    begin
      cnt_r <= 4'h0;
      ovf_r <= 1'b0;
      crc_r <= coil_link_pkg::CRC_INIT;
      if (reply && !write_ok)
      begin
        buf_r[1] <= buf_r[1] | coil_link_pkg::EXC_FLAG;
        buf_r[2] <= exc_code;
      end
    end
    else if (rx_byte)
    begin
      crc_r <= coil_link_pkg::crc_step(crc_r, link.q_data);
      if (cnt_r == coil_link_pkg::FRAME_BYTES)
      begin
        ovf_r <= 1'b1;
      end
      else
      begin
        buf_r[cnt_r[2:0]] <= link.q_data;
        cnt_r <= cnt_r + 4'h1;
      end
    end
    else if (tx_fire && tx_idx_r < coil_link_pkg::EXC_BODY)
    begin
      crc_r <= coil_link_pkg::crc_step(crc_r, tx_byte);
    end
    else if (tx_last)
    begin
      crc_r <= coil_link_pkg::CRC_INIT;
    end
  end

  // Reply sender, one byte every BYTE_CYC cycles
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_idx_r  <= 4'h0;
      tx_len_r  <= 4'h0;
      tx_exc_r  <= 1'b0;
      pace_r    <= 8'h00;
      r_data_r  <= 8'h00;
      r_valid_r <= 1'b0;
    end
    else
    begin
      r_valid_r <= tx_fire;
      if (reply)
      begin
        tx_idx_r <= 4'h0;
        tx_exc_r <= !write_ok;
        tx_len_r <= write_ok ? coil_link_pkg::FRAME_BYTES : coil_link_pkg::EXC_BYTES;
        pace_r   <= 8'h00;
      end
      else if (tx_fire)
      begin
        r_data_r <= tx_byte;
        tx_idx_r <= tx_idx_r + 4'h1;
        pace_r   <= BYTE_N;
      end
      else if (pace_r != 8'h00)
      begin
        pace_r <= pace_r - 8'h01;
      end
    end
  end

  // Coil storage and home edge detection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      home_r   <= 1'b0;
      search_r <= 1'b0;
      start_r  <= 1'b0;
      drop_r   <= 1'b0;
    end
    else
    begin
      start_r <= write_ok && is_home && data_on && !home_r;
      drop_r  <= frame_end && !accept;
      if (write_ok && is_home)
      begin
        home_r <= data_on;
      end
      if (write_ok && is_search)
      begin
        search_r <= data_on;
      end
    end
  end

  assign link.r_data     = r_data_r;
  assign link.r_valid    = r_valid_r;
  assign home_move_start = start_r;
  assign home_coil       = home_r;
  assign search_end_stop = search_r;
  assign frame_drop      = drop_r;

endmodule : coil_slave
`default_nettype wire

// *** coil_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module coil_master #(
  parameter int SILENT_CYC = coil_link_pkg::SILENT_CYC,
  parameter int BYTE_CYC   = coil_link_pkg::BYTE_CYC,
  parameter int RESP_CYC   = coil_link_pkg::RESP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  coil_link_if.master      link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_slave,
  input  wire logic [15:0] cmd_coil,
  input  wire logic [15:0] cmd_data,
  input  wire logic        cmd_edge,
  output logic             resp_valid,
  output logic             resp_ok,
  output logic             resp_exc,
  output logic [7:0]       resp_code
);

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_TX   = 2'b01,
    M_RX   = 2'b10
  } master_state_t;

  localparam logic [7:0] SILENT_N = 8'(SILENT_CYC);
  localparam logic [7:0] BYTE_N   = 8'(BYTE_CYC - 1);
  localparam logic [7:0] RESP_N   = 8'(RESP_CYC);

  master_state_t state_r;
  logic [7:0]    q_r [0:7];
  logic [7:0]    a_r [0:7];
  logic [3:0]    idx_r;
  logic [3:0]    acnt_r;
  logic [15:0]   crc_r;
  logic [15:0]   acrc_r;
  logic [7:0]    cnt_r;
  logic [7:0]    pace_r;
  logic [15:0]   final_r;
  logic          first_r;
  logic          q_valid_r;
  logic [7:0]    q_data_r;
  logic          rv_r;
  logic          rok_r;
  logic          rexc_r;
  logic [7:0]    rcode_r;

  wire       fire     = (state_r == M_TX) && (pace_r == 8'h00);
  wire       last     = fire && (idx_r == coil_link_pkg::FRAME_BYTES - 4'h1);
  wire [7:0] q_byte   = (idx_r < coil_link_pkg::QUERY_BODY) ? q_r[idx_r[2:0]] :
                        (idx_r == coil_link_pkg::QUERY_BODY) ? crc_r[7:0] : crc_r[15:8];
  wire       rx_end   = (state_r == M_RX) && (cnt_r >= (acnt_r == 4'h0 ? RESP_N : SILENT_N));
  wire       a_crc_ok = acrc_r == coil_link_pkg::CRC_RESIDUE;
  wire       echo_ok  = a_crc_ok && (acnt_r == coil_link_pkg::FRAME_BYTES)
                        && (a_r[0] == q_r[0]) && (a_r[1] == q_r[1]) && (a_r[2] == q_r[2])
                        && (a_r[3] == q_r[3]) && (a_r[4] == q_r[4]) && (a_r[5] == q_r[5]);
  wire       exc_ok   = a_crc_ok && (acnt_r == coil_link_pkg::EXC_BYTES)
                        && (a_r[1] == (q_r[1] | coil_link_pkg::EXC_FLAG));
  wire       bcast    = q_r[0] == coil_link_pkg::ADDR_BROADCAST;
  wire       pass     = echo_ok || (bcast && acnt_r == 4'h0);
  wire       again    = rx_end && first_r && pass;

  assign cmd_ready = (state_r == M_IDLE) && (cnt_r >= SILENT_N);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= M_IDLE;
      idx_r   <= 4'h0;
      pace_r  <= 8'h00;
      cnt_r   <= 8'h00;
      crc_r   <= coil_link_pkg::CRC_INIT;
      first_r <= 1'b0;
      final_r <= 16'h0000;
      for (int i = 0; i < 8; i++)
      begin
        q_r[i] <= 8'h00;
      end
    end
    else
    begin
      cnt_r <= (link.r_valid || fire) ? 8'h00 : ((cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01);
      case (state_r)
        M_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            q_r[0]  <= cmd_slave;
            q_r[1]  <= coil_link_pkg::FUNC_WRITE_COIL;
            q_r[2]  <= cmd_coil[15:8];
            q_r[3]  <= cmd_coil[7:0];
            q_r[4]  <= cmd_edge ? coil_link_pkg::DATA_OFF[15:8] : cmd_data[15:8];
            q_r[5]  <= cmd_edge ? coil_link_pkg::DATA_OFF[7:0] : cmd_data[7:0];
            final_r <= cmd_data;
            first_r <= cmd_edge;
            idx_r   <= 4'h0;
            pace_r  <= 8'h00;
            crc_r   <= coil_link_pkg::CRC_INIT;
            state_r <= M_TX;
          end
        end
        M_TX:
        begin
          if (fire)
          begin
            idx_r  <= idx_r + 4'h1;
            pace_r <= BYTE_N;
            if (idx_r < coil_link_pkg::QUERY_BODY)
            begin
              crc_r <= coil_link_pkg::crc_step(crc_r, q_byte);
            end
            if (last)
            begin
              state_r <= M_RX;
            end
          end
          else if (pace_r != 8'h00)
          begin
            pace_r <= pace_r - 8'h01;
          end
        end
        M_RX:
        begin
          if (again)
          begin
            q_r[4]  <= final_r[15:8];
            q_r[5]  <= final_r[7:0];
            first_r <= 1'b0;
            idx_r   <= 4'h0;
            crc_r   <= coil_link_pkg::CRC_INIT;
            state_r <= M_TX;
          end
          else if (rx_end)
          begin
            state_r <= M_IDLE;
          end
        end
        default:
        begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end

  // Answer capture, ended by silence
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acnt_r <= 4'h0;
      acrc_r <= coil_link_pkg::CRC_INIT;
      for (int i = 0; i < 8; i++)
      begin
        a_r[i] <= 8'h00;
      end
    end
    else if (state_r != M_RX)
    begin
      acnt_r <= 4'h0;
      acrc_r <= coil_link_pkg::CRC_INIT;
    end
    else if (link.r_valid)
    begin
      acrc_r <= coil_link_pkg::crc_step(acrc_r, link.r_data);
      if (acnt_r != coil_link_pkg::FRAME_BYTES)
      begin
        a_r[acnt_r[2:0]] <= link.r_data;
        acnt_r <= acnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q_valid_r <= 1'b0;
      q_data_r  <= 8'h00;
      rv_r      <= 1'b0;
      rok_r     <= 1'b0;
      rexc_r    <= 1'b0;
      rcode_r   <= 8'h00;
    end
    else
    begin
      q_valid_r <= fire;
      if (fire)
      begin
        q_data_r <= q_byte;
      end
      rv_r <= rx_end && !again;
      if (rx_end && !again)
      begin
        rok_r   <= pass;
        rexc_r  <= exc_ok;
        rcode_r <= exc_ok ? a_r[2] : 8'h00;
      end
    end
  end

  assign link.q_valid = q_valid_r;
  assign link.q_data  = q_data_r;
  assign resp_valid   = rv_r;
  assign resp_ok      = rok_r;
  assign resp_exc     = rexc_r;
  assign resp_code    = rcode_r;

endmodule : coil_master
`default_nettype wire

// *** coil_link_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module coil_link_asserts #(
  parameter int SILENT_CYC = 16,
  parameter int BYTE_CYC   = 4
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] q_data,
  input wire logic       q_valid,
  input wire logic [7:0] r_data,
  input wire logic       r_valid
);
  logic [7:0]  q_idle_r;
  logic [3:0]  q_cnt_r;
  logic [3:0]  r_idx_r;
  logic        r_exc_r;
  logic [15:0] q_crc_r;
  logic [7:0]  q_buf_r [8];
  wire         q_gap   = q_idle_r >= 8'(SILENT_CYC);
  wire         q_first = q_valid && q_gap;
  wire  [3:0]  q_idx   = q_first ? 4'h0 : q_cnt_r;
  wire  [15:0] crc_in  = q_first ? 16'hFFFF : q_crc_r;

  // Line starts out silent, so no frame end is seen at reset
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) q_idle_r <= 8'(SILENT_CYC);
    else q_idle_r <= q_valid ? 8'h00 : (q_gap ? q_idle_r : q_idle_r + 8'h01);

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) q_cnt_r <= 4'h0;
    else if (q_valid) q_cnt_r <= (q_idx == 4'hF) ? q_idx : q_idx + 4'h1;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) q_crc_r <= 16'hFFFF;
    else if (q_valid) q_crc_r <= coil_link_pkg::crc_step(crc_in, q_data);

  always_ff @(posedge clk)
    if (q_valid && q_idx < 4'h8) q_buf_r[q_idx[2:0]] <= q_data;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) r_idx_r <= 4'h0;
    else if (q_valid) r_idx_r <= 4'h0;
    else if (r_valid) r_idx_r <= r_idx_r + 4'h1;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) r_exc_r <= 1'b0;
    else if (r_valid && r_idx_r == 4'h1) r_exc_r <= r_data[7];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_q_quiet;
    !q_valid [*3];
  endsequence
  sequence s_r_quiet;
    !r_valid [*3];
  endsequence

  a_query_spacing: assert property (q_valid |=> s_q_quiet)
    else $error("query bytes too close");
  a_reply_spacing: assert property (r_valid |=> s_r_quiet)
    else $error("reply bytes too close");
  a_half_duplex: assert property (q_valid |-> !r_valid)
    else $error("reply during query");
  a_reply_gap: assert property (r_valid |-> q_idle_r >= 8'(SILENT_CYC))
    else $error("reply without silent gap");
  a_query_length: assert property ($rose(q_gap) |-> q_cnt_r == 4'h8)
    else $error("query not eight bytes");
  a_query_crc: assert property ($rose(q_gap) |-> q_crc_r == 16'h0000)
    else $error("query check value wrong");
  a_query_func: assert property (q_valid && !q_gap && q_cnt_r == 4'h1 |-> q_data == 8'h05)
    else $error("query function not coil write");
  a_echo_addr: assert property (r_valid && r_idx_r == 4'h0 |-> r_data == q_buf_r[0] && r_data != 8'h00)
    else $error("reply address wrong");
  a_exc_func: assert property (r_valid && r_idx_r == 4'h1 |-> r_data == q_buf_r[1] || r_data == (q_buf_r[1] | 8'h80))
    else $error("reply function wrong");
  a_exc_code: assert property (r_valid && r_idx_r == 4'h2 && r_exc_r |-> r_data inside {8'h01, 8'h02, 8'h03})
    else $error("exception code out of range");
  a_echo_body: assert property (r_valid && r_idx_r >= 4'h2 && !r_exc_r |-> r_data == q_buf_r[r_idx_r[2:0]])
    else $error("echo differs from query");
endmodule : coil_link_asserts
`default_nettype wire

// *** test_press_home_search_coil_cmd.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_press_home_search_coil_cmd;
  typedef struct {logic ok; logic exc; logic [7:0] code; logic hc; logic ss; int pul; int drp;} note_t;
  logic        clk, rst_b, cmd_valid, cmd_ready, cmd_edge, resp_valid, resp_ok, resp_exc;
  logic [7:0]  cmd_slave, resp_code, own;
  logic [15:0] cmd_coil, cmd_data;
  logic [3:0]  axis;
  logic        hms, hc, ss, fd, hms2, hc2, ss2, fd2;
  logic [31:0] seed;
  logic [15:0] crc_q, crc_e;
  int          error_cnt, cmp_count, rsp_seen, pul, drp, pul2, drp2;
  note_t       mdl, nt;
  note_t       note_q[$];
  logic [7:0]  echo_q[$];

  coil_link_if lnk (.clk(clk));
  coil_link_if lnk2 (.clk(clk));
  coil_master coil_master_i (.clk(clk), .rst_b(rst_b), .link(lnk.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_slave(cmd_slave), .cmd_coil(cmd_coil), .cmd_data(cmd_data),
    .cmd_edge(cmd_edge), .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_exc(resp_exc),
    .resp_code(resp_code));
  coil_slave coil_slave_i (.clk(clk), .rst_b(rst_b), .link(lnk.slave), .axis_no(axis),
    .home_move_start(hms), .home_coil(hc), .search_end_stop(ss), .frame_drop(fd));
  coil_slave coil_slave_i2 (.clk(clk), .rst_b(rst_b), .link(lnk2.slave), .axis_no(4'h0),
    .home_move_start(hms2), .home_coil(hc2), .search_end_stop(ss2), .frame_drop(fd2));
  coil_link_asserts coil_link_asserts_i (.clk(clk), .rst_b(rst_b), .q_data(lnk.q_data),
    .q_valid(lnk.q_valid), .r_data(lnk.r_data), .r_valid(lnk.r_valid));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Independent check value over the leading bytes of a frame
  function automatic logic [15:0] crc_b(input logic [71:0] fr, input int len);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < len; i++)
    begin
      c ^= {8'h00, fr[71-8*i -: 8]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc_b

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      $display("mismatch %s expected %0h seen %0h", name, want, seen);
      error_cnt++;
    end
  endtask : check

  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Model the coils, queue the note, then issue one command
  task automatic run_cmd(input logic [7:0] sa, input logic [15:0] coil, input logic [15:0] dat,
                         input logic edg);
    logic bc;
    logic hit;
    logic good;
    int   n;
    bc       = sa == 8'h00;
    hit      = bc || sa == own;
    good     = coil[15:1] == 15'h024E && (dat == 16'hFF00 || dat == 16'h0000);
    mdl.ok   = bc || (hit && good);
    mdl.exc  = hit && !bc && !good;
    mdl.code = !mdl.exc ? 8'h00 : (coil[15:1] == 15'h024E ? 8'h03 : 8'h02);
    mdl.drp += int'(!hit);
    if (hit && good && coil == 16'h049C)
    begin
      if (dat == 16'hFF00 && !(mdl.hc && !edg)) mdl.pul++;
      mdl.hc = dat == 16'hFF00;
    end
    if (hit && good && coil == 16'h049D) mdl.ss = dat == 16'hFF00;
    note_q.push_back(mdl);
    {cmd_slave, cmd_coil, cmd_data, cmd_edge} = {sa, coil, dat, edg};
    cmd_valid = 1'b1;
    for (n = 0; n < 500 && cmd_ready !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = rsp_seen;
    for (int i = 0; i < 1500 && rsp_seen == n; i++) @(posedge clk);
    #1;
  endtask : run_cmd

  // Raw bytes on the second link, idle data inverted between bytes
  task automatic send_raw(input logic [71:0] fr, input int len, input logic echo);
    for (int i = 0; i < len; i++)
    begin
      if (echo) echo_q.push_back(fr[71-8*i -: 8]);
      lnk2.q_data  = fr[71-8*i -: 8];
      lnk2.q_valid = 1'b1;
      @(posedge clk);
      #1;
      lnk2.q_valid = 1'b0;
      lnk2.q_data  = ~lnk2.q_data;
      repeat (3) @(posedge clk);
      #1;
    end
    repeat (100) @(posedge clk);
    #1;
  endtask : send_raw

  always @(negedge clk)
  begin
    if (hms === 1'b1) pul++;
    if (fd === 1'b1) drp++;
    if (hms2 === 1'b1) pul2++;
    if (fd2 === 1'b1) drp2++;
    if (lnk2.r_valid === 1'b1)
      check("echo", lnk2.r_data, echo_q.size() > 0 ? echo_q.pop_front() : 8'hXX);
    if (resp_valid === 1'b1)
    begin
      nt = note_q.pop_front();
      check("ok", resp_ok, nt.ok);
      check("exc", resp_exc, nt.exc);
      check("code", resp_code, nt.code);
      check("home", hc, nt.hc);
      check("search", ss, nt.ss);
      check("starts", pul, nt.pul);
      check("drops", drp, nt.drp);
      rsp_seen++;
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    seed = xs(32'd63);
    axis = seed[3:0];
    own  = {4'h0, axis} + 8'h01;
    {rst_b, cmd_valid, cmd_edge, cmd_slave, cmd_coil, cmd_data} = '0;
    lnk2.q_valid = 1'b0;
    lnk2.q_data  = 8'h00;
    mdl = '{1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 0, 0};
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    run_cmd(own, 16'h049C, 16'hFF00, 1'b1);
    run_cmd(own, 16'h049C, 16'hFF00, 1'b0);
    run_cmd(own, 16'h049C, 16'h0000, 1'b0);
    run_cmd(own, 16'h049C, 16'hFF00, 1'b0);
    run_cmd(own, 16'h049D, 16'hFF00, 1'b0);
    run_cmd(own, 16'h049D, 16'h0000, 1'b0);
    run_cmd(8'h00, 16'h049D, 16'hFF00, 1'b0);
    run_cmd(own, 16'h049E, 16'hFF00, 1'b0);
    run_cmd(own, 16'h049D, 16'h1234, 1'b0);
    run_cmd(own ^ 8'h20, 16'h049C, 16'h0000, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      run_cmd(seed[1:0] == 2'h0 ? 8'h00 : (seed[1:0] == 2'h1 ? own ^ 8'h20 : own),
              {15'h024E, seed[2]},
              seed[4:3] == 2'h0 ? seed[31:16] : (seed[3] ? 16'hFF00 : 16'h0000),
              seed[5] & seed[4]);
    end
    send_raw(72'h0105049C00000CD400, 8, 1'b1);
    send_raw(72'h0105049CFF004D2400, 8, 1'b1);
    send_raw(72'h0105049DFF001CE500, 8, 1'b0);
    send_raw(72'h0105049DFF001CE400, 7, 1'b0);
    send_raw(72'h0105049DFF001CE400, 9, 1'b0);
    send_raw(72'h0105049DFF001CE400, 8, 1'b1);
    crc_e  = crc_b(72'h018601000000000000, 3);
    echo_q = {echo_q, 8'h01, 8'h86, 8'h01, crc_e[7:0], crc_e[15:8]};
    crc_q  = crc_b(72'h0106049CFF00000000, 6);
    send_raw({48'h0106049CFF00, crc_q[7:0], crc_q[15:8], 8'h00}, 8, 1'b0);
    check("starts2", pul2, 1);
    check("drops2", drp2, 3);
    check("search2", ss2, 1'b1);
    check("home2", hc2, 1'b1);
    check("pending", echo_q.size() + note_q.size(), 0);
    complete_run();
  end
endmodule : test_press_home_search_coil_cmd
`default_nettype wire
